// [cmdset_brake_params.svh]
// Notes on behaviour
// RULE1 - Active command set chosen by two selection inputs
// RULE2 - Set changeover completes well within four milliseconds
// RULE3 - Set count accepts only 2, 3, 4; resets 2
// RULE4 - Count written only while commissioning filter is 15
// RULE5 - Software writes copy source and target first
// RULE6 - Copy on start rising; device clears start itself
// RULE7 - Readable active command set number
// RULE8 - Motor stays energized while brake is open; in brake mode open the code holds the brake open with the motor off
// RULE9 - On: energize, open brake after magnetizing time
// RULE10 - Hold zero speed until brake open time elapses
// RULE11 - Ramp or quick stop decelerates before closing
// RULE12 - Setpoint and actual below threshold start timers
// RULE13 - First expiring stop timer closes the brake
// RULE14 - De-energize after brake close time elapses
// RULE15 - Coast stop closes brake immediately
// RULE16 - Software enables sequencing with brake mode one
// RULE17 - Brake modes: locked, sequence, open, interconnected
// RULE18 - Software keeps magnetizing time above zero
// RULE19 - Software sizes open and close times
// RULE20 - Start effort chosen by control mode select
// RULE21 - Active index is hi times two plus lo
// RULE22 - Coast stop aborts sequence, clears all timers
`ifndef CMDSET_BRAKE_PARAMS_SVH
`define CMDSET_BRAKE_PARAMS_SVH
`define CLK_PERIOD_NS     25
`define MS_NS             1000000
`define MS_CYCLES         (`MS_NS / `CLK_PERIOD_NS)
`define OFS_CTRL          7'h00
`define OFS_CMDSET        7'h04
`define OFS_COPY          7'h08
`define OFS_MAG_TIME      7'h0c
`define OFS_OPEN_TIME     7'h10
`define OFS_CLOSE_TIME    7'h14
`define OFS_WATCH_TIME    7'h18
`define OFS_PULSE_DELAY   7'h1c
`define OFS_THRESHOLD     7'h20
`define OFS_CTRL_MODE     7'h24
`define OFS_BOOST         7'h28
`define OFS_SLIP          7'h2c
`define OFS_TORQUE        7'h30
`define OFS_STATUS        7'h34
`define OFS_SET_CFG       7'h40
`define FILTER_COMMISSION 4'hf
`define COUNT_RESET       3'h2
`define COUNT_MIN         3'h2
`define COUNT_MAX         3'h4
`define MODE_LOCKED       2'h0
`define MODE_SEQUENCE     2'h1
`define MODE_OPEN         2'h2
`define MODE_INTERCONNECT 2'h3
`define VF_MODE_MAX       5'h03
`define VECTOR_MODE_MIN   5'h14
`define SRC_LOCAL_BIT     0
`endif

// [cmdset_brake_pkg.sv]
`default_nettype none
package cmdset_brake_pkg;
  typedef enum logic [2:0] {st_idle, st_magnetize, st_opening, st_run, st_stopping, st_closing} brake_state_t;
  typedef logic [15:0] ms_time_t;
endpackage : cmdset_brake_pkg
`default_nettype wire

// [cmdset_switch_brake_sequencer.sv]
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`include "cmdset_brake_params.svh"
`default_nettype none
module cmdset_switch_brake_sequencer #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire logic [6:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      command_set_select_lo,
  input  wire logic                      command_set_select_hi,
  input  wire logic                      local_on,
  input  wire logic                      local_ramp_stop,
  input  wire logic                      local_quick_stop,
  input  wire logic                      local_coast_stop,
  input  wire logic                      interconnect_on,
  input  wire cmdset_brake_pkg::ms_time_t speed_setpoint,
  input  wire cmdset_brake_pkg::ms_time_t actual_speed,
  output logic      [1:0]                active_command_set,
  output logic                           motor_on,
  output logic                           brake_open,
  output logic                           hold_zero_speed,
  output logic                           decel_request,
  output logic      [15:0]               start_voltage_boost,
  output logic      [15:0]               start_slip_freq,
  output logic      [15:0]               start_torque
);
  import cmdset_brake_pkg::*;

  // Software state
  logic [3:0]   on_bits;
  logic [1:0]   brake_function_mode;
  logic [3:0]   commissioning_filter;
  logic [2:0]   command_set_count;
  logic [1:0]   copy_src;
  logic [1:0]   copy_tgt;
  logic         copy_start;
  ms_time_t     magnetizing_time;
  ms_time_t     brake_open_time;
  ms_time_t     brake_close_time;
  ms_time_t     standstill_watch_time;
  ms_time_t     pulse_cancel_delay;
  ms_time_t     standstill_speed_threshold;
  logic [4:0]   control_mode_select;
  logic [15:0]  voltage_boost;
  logic [15:0]  starting_slip_frequency;
  logic [15:0]  starting_torque_setpoint;
  logic [15:0]  set_cfg [4];
  logic         wr_ok;
  logic [1:0]   wr_idx;

  assign wr_ok  = avs_write && !avs_waitrequest;
  assign wr_idx = avs_address[3:2];

  // Bus slave: one wait cycle, then a single ready cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Control and timing registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      on_bits                    <= 4'h0;
      brake_function_mode        <= `MODE_LOCKED;
      commissioning_filter       <= 4'h0;
      magnetizing_time           <= 16'h0000;
      brake_open_time            <= 16'h0000;
      brake_close_time           <= 16'h0000;
      standstill_watch_time      <= 16'h0000;
      pulse_cancel_delay         <= 16'h0000;
      standstill_speed_threshold <= 16'h0000;
      control_mode_select        <= 5'h00;
      voltage_boost              <= 16'h0000;
      starting_slip_frequency    <= 16'h0000;
      starting_torque_setpoint   <= 16'h0000;
    end else if (wr_ok) begin
      case (avs_address)
        `OFS_CTRL: begin
          on_bits             <= avs_writedata[3:0];
          brake_function_mode <= avs_writedata[5:4];
        end
        `OFS_CMDSET:      commissioning_filter       <= avs_writedata[3:0];
        `OFS_MAG_TIME:    magnetizing_time           <= avs_writedata[15:0];
        `OFS_OPEN_TIME:   brake_open_time            <= avs_writedata[15:0];
        `OFS_CLOSE_TIME:  brake_close_time           <= avs_writedata[15:0];
        `OFS_WATCH_TIME:  standstill_watch_time      <= avs_writedata[15:0];
        `OFS_PULSE_DELAY: pulse_cancel_delay         <= avs_writedata[15:0];
        `OFS_THRESHOLD:   standstill_speed_threshold <= avs_writedata[15:0];
        `OFS_CTRL_MODE:   control_mode_select        <= avs_writedata[4:0];
        `OFS_BOOST:       voltage_boost              <= avs_writedata[15:0];
        `OFS_SLIP:        starting_slip_frequency    <= avs_writedata[15:0];
        `OFS_TORQUE:      starting_torque_setpoint   <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end

  // RULE3 count range gate
  // Out of range values or writes outside commissioning are dropped
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      command_set_count <= `COUNT_RESET;
    end else if (wr_ok && avs_address == `OFS_CMDSET && commissioning_filter == `FILTER_COMMISSION
                 && avs_writedata[6:4] >= `COUNT_MIN && avs_writedata[6:4] <= `COUNT_MAX) begin
      command_set_count <= avs_writedata[6:4];
    end
  end

  // RULE6 copy start and self clear
  // Start only latches on a 0 to 1 write; the copy runs next cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      copy_src   <= 2'h0;
      copy_tgt   <= 2'h0;
      copy_start <= 1'b0;
    end else if (wr_ok && avs_address == `OFS_COPY) begin
      copy_src   <= avs_writedata[1:0];
      copy_tgt   <= avs_writedata[3:2];
      copy_start <= avs_writedata[4] && !copy_start;
    end else begin
      copy_start <= 1'b0;
    end
  end

  // Per-set source configuration; copy wins over a bus write that lands the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        set_cfg[i] <= 16'h0000;
      end
    end else if (copy_start) begin
      set_cfg[copy_tgt] <= set_cfg[copy_src];
    end else if (wr_ok && avs_address[6:4] == 3'(`OFS_SET_CFG >> 4)) begin
      set_cfg[wr_idx] <= avs_writedata[15:0];
    end
  end

  // Pin synchronisers, two stages before any reader
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end else begin
      pin_meta <= {interconnect_on, local_coast_stop, local_quick_stop, local_ramp_stop,
                   local_on, command_set_select_hi, command_set_select_lo};
      pin_sync <= pin_meta;
    end
  end

  // RULE21 index from selection bits
  logic [2:0] sel_index;
  assign sel_index = {1'b0, pin_sync[1], pin_sync[0]};

  // RULE1 active set update
  // RULE2 changeover in three cycles
  // A selection beyond the configured count keeps the previous set
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      active_command_set <= 2'h0;
    end else if (sel_index < command_set_count) begin
      active_command_set <= sel_index[1:0];
    end
  end

  // Command source of the active set
  logic local_src;
  logic cmd_on;
  logic cmd_ramp;
  logic cmd_quick;
  logic cmd_coast;
  logic seq_en;
  assign local_src = set_cfg[active_command_set][`SRC_LOCAL_BIT];
  assign seq_en    = brake_function_mode == `MODE_SEQUENCE || brake_function_mode == `MODE_INTERCONNECT;
  assign cmd_on    = brake_function_mode == `MODE_INTERCONNECT ? pin_sync[6]
                   : (local_src ? pin_sync[2] : on_bits[0]);
  assign cmd_ramp  = local_src ? pin_sync[3] : on_bits[1];
  assign cmd_quick = local_src ? pin_sync[4] : on_bits[2];
  assign cmd_coast = local_src ? pin_sync[5] : on_bits[3];

  // Millisecond tick shared by all brake timers
  logic [31:0] tick_cnt;
  logic        ms_tick;
  assign ms_tick = tick_cnt == 32'(MS_CYCLES - 1);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= ms_tick ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  brake_state_t state;
  brake_state_t next_state;
  ms_time_t     phase_ms;
  ms_time_t     watch_ms;
  ms_time_t     pulse_ms;
  logic         watch_run;
  logic         pulse_run;
  logic         stop_req;
  logic         stop_done;
  assign stop_req  = cmd_ramp || cmd_quick || !cmd_on;
  // RULE13 first expiry closes
  assign stop_done = (watch_run && watch_ms >= standstill_watch_time)
                  || (pulse_run && pulse_ms >= pulse_cancel_delay);

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      st_idle:      if (cmd_on && !stop_req && !cmd_coast) next_state = seq_en ? st_magnetize : st_run;
      // RULE9 open after magnetizing
      st_magnetize: if (phase_ms >= magnetizing_time) next_state = st_opening;
      // RULE10 release after opening time
      st_opening:   if (phase_ms >= brake_open_time) next_state = st_run;
      // RULE11 decelerate first
      st_run:       if (stop_req) next_state = st_stopping;
      st_stopping:  if (stop_done) next_state = seq_en ? st_closing : st_idle;
      // RULE14 off after closing time
      st_closing:   if (phase_ms >= brake_close_time) next_state = st_idle;
      default:      next_state = st_idle;
    endcase
    // RULE15 coast closes at once
    if (cmd_coast) next_state = st_idle;
  end

  // RULE22 coast clears every timer
  // RULE12 standstill timers start
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= st_idle;
      phase_ms  <= 16'h0000;
      watch_ms  <= 16'h0000;
      pulse_ms  <= 16'h0000;
      watch_run <= 1'b0;
      pulse_run <= 1'b0;
    end else begin
      state     <= next_state;
      phase_ms  <= next_state != state ? 16'h0000 : phase_ms + 16'(ms_tick && phase_ms != 16'hffff);
      watch_run <= next_state == st_stopping && (watch_run || speed_setpoint < standstill_speed_threshold);
      pulse_run <= next_state == st_stopping && (pulse_run || actual_speed < standstill_speed_threshold);
      watch_ms  <= watch_run ? watch_ms + 16'(ms_tick && watch_ms != 16'hffff) : 16'h0000;
      pulse_ms  <= pulse_run ? pulse_ms + 16'(ms_tick && pulse_ms != 16'hffff) : 16'h0000;
    end
  end

  // RULE8 energized while open in sequence and interconnected modes
  // RULE17 brake mode decoding
  // Outputs are registered from the next state so they never glitch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      motor_on        <= 1'b0;
      brake_open      <= 1'b0;
      hold_zero_speed <= 1'b0;
      decel_request   <= 1'b0;
    end else begin
      motor_on        <= next_state != st_idle;
      hold_zero_speed <= next_state == st_magnetize || next_state == st_opening;
      decel_request   <= next_state == st_stopping;
      case (brake_function_mode)
        `MODE_OPEN:   brake_open <= 1'b1;
        `MODE_LOCKED: brake_open <= 1'b0;
        default:      brake_open <= next_state == st_opening || next_state == st_run || next_state == st_stopping;
      endcase
    end
  end

  // RULE20 start effort selection
  // Control modes between the two ranges apply no extra effort
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      start_voltage_boost <= 16'h0000;
      start_slip_freq     <= 16'h0000;
      start_torque        <= 16'h0000;
    end else begin
      start_voltage_boost <= (next_state == st_opening && control_mode_select <= `VF_MODE_MAX) ? voltage_boost : 16'h0;
      start_slip_freq     <= (next_state == st_opening && control_mode_select <= `VF_MODE_MAX)
                             ? starting_slip_frequency : 16'h0;
      start_torque        <= (next_state == st_opening && control_mode_select >= `VECTOR_MODE_MIN)
                             ? starting_torque_setpoint : 16'h0;
    end
  end

  // RULE7 status readback
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `OFS_CTRL:        avs_readdata <= {26'h0, brake_function_mode, on_bits};
        `OFS_CMDSET:      avs_readdata <= {25'h0, command_set_count, commissioning_filter};
        `OFS_COPY:        avs_readdata <= {27'h0, copy_start, copy_tgt, copy_src};
        `OFS_MAG_TIME:    avs_readdata <= {16'h0, magnetizing_time};
        `OFS_OPEN_TIME:   avs_readdata <= {16'h0, brake_open_time};
        `OFS_CLOSE_TIME:  avs_readdata <= {16'h0, brake_close_time};
        `OFS_WATCH_TIME:  avs_readdata <= {16'h0, standstill_watch_time};
        `OFS_PULSE_DELAY: avs_readdata <= {16'h0, pulse_cancel_delay};
        `OFS_THRESHOLD:   avs_readdata <= {16'h0, standstill_speed_threshold};
        `OFS_CTRL_MODE:   avs_readdata <= {27'h0, control_mode_select};
        `OFS_BOOST:       avs_readdata <= {16'h0, voltage_boost};
        `OFS_SLIP:        avs_readdata <= {16'h0, starting_slip_frequency};
        `OFS_TORQUE:      avs_readdata <= {16'h0, starting_torque_setpoint};
        `OFS_STATUS:      avs_readdata <= {24'h0, 1'b0, state, brake_open, motor_on, active_command_set};
        `OFS_SET_CFG, `OFS_SET_CFG + 7'h04, `OFS_SET_CFG + 7'h08, `OFS_SET_CFG + 7'h0c:
                          avs_readdata <= {16'h0, set_cfg[wr_idx]};
        default:          avs_readdata <= 32'h0;
      endcase
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_count_range: assert property (command_set_count >= 3'h2 && command_set_count <= 3'h4) // RULE3
    else $error("command set count out of range");
  a_copy_selfclear: assert property (copy_start |=> !copy_start) // RULE6
    else $error("copy start not cleared");
  a_set_follows: assert property ((sel_index < command_set_count) [*2] |=> active_command_set == $past(sel_index[1:0])) // RULE1
    else $error("active set did not follow selection");
  a_open_energized: assert property (seq_en && $past(seq_en) && brake_open |-> motor_on) // RULE8
    else $error("brake open with motor off");
  a_open_after_mag: assert property (state == st_magnetize && next_state == st_opening |=> brake_open || !seq_en) // RULE9
    else $error("brake not opened after magnetizing");
  a_hold_opening: assert property (state == st_opening |-> hold_zero_speed) // RULE10
    else $error("speed released before open time");
  a_coast_closes: assert property (cmd_coast && seq_en |=> !brake_open ##1 !brake_open && state == st_idle) // RULE15
    else $error("coast stop did not close brake");
  a_close_then_off: assert property (state == st_closing |-> motor_on && !(brake_open && seq_en)) // RULE14
    else $error("motor off before brake close time");
  a_torque_mode: assert property (start_torque != 16'h0 |-> $past(control_mode_select) >= 5'h14) // RULE20
    else $error("torque effort in wrong control mode");
endmodule : cmdset_switch_brake_sequencer
`default_nettype wire

// [motor_brake_model.sv]
`default_nettype none
module motor_brake_model #(
  parameter int MECH_CYCLES = 5,
  parameter int RAMP_STEP   = 2
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        motor_on,
  input  wire logic        brake_open,
  input  wire logic        hold_zero_speed,
  input  wire logic        decel_request,
  input  wire logic [15:0] target_speed,
  output logic      [15:0] speed_setpoint,
  output logic      [15:0] actual_speed
);
  int shoe;

  // mechanical brake lag
  // Shoe travel is kept shorter than the open and close times the bench sets
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      shoe <= 0;
    else if (brake_open && shoe < MECH_CYCLES)
      shoe <= shoe + 1;
    else if (!brake_open && shoe > 0)
      shoe <= shoe - 1;
  end

  // Ramp generator: down while held or stopping, up toward target in run
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      speed_setpoint <= 16'h0000;
    else if (hold_zero_speed || decel_request || !motor_on)
      speed_setpoint <= (speed_setpoint > 16'(RAMP_STEP)) ? speed_setpoint - 16'(RAMP_STEP) : 16'h0000;
    else if (speed_setpoint < target_speed)
      speed_setpoint <= speed_setpoint + 16'(RAMP_STEP);
  end

  // Shaft trails the setpoint and stays locked while the shoe still grips
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      actual_speed <= 16'h0000;
    else
      actual_speed <= (shoe == MECH_CYCLES) ? speed_setpoint : 16'h0000;
  end
endmodule : motor_brake_model
`default_nettype wire

// [cmdset_switch_brake_sequencer_tb.sv]
`include "cmdset_brake_params.svh"
`default_nettype none
module cmdset_switch_brake_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, nrst, avs_read, avs_write, avs_waitrequest, sel_lo, sel_hi;
  logic        local_on, local_ramp_stop, local_quick_stop, local_coast_stop, interconnect_on;
  logic        motor_on, brake_open, hold_zero_speed, decel_request, seq_watch;
  logic [6:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [15:0] speed_setpoint, actual_speed, target_speed, boost, slip, torque;
  logic [1:0]  active_command_set;
  int          miscompares, checks, n;

  // Ten cycles per millisecond keeps every phase short
  cmdset_switch_brake_sequencer #(.MS_CYCLES(10)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .command_set_select_lo(sel_lo),
    .command_set_select_hi(sel_hi), .local_on(local_on), .local_ramp_stop(local_ramp_stop),
    .local_quick_stop(local_quick_stop), .local_coast_stop(local_coast_stop),
    .interconnect_on(interconnect_on), .speed_setpoint(speed_setpoint),
    .actual_speed(actual_speed), .active_command_set(active_command_set),
    .motor_on(motor_on), .brake_open(brake_open), .hold_zero_speed(hold_zero_speed),
    .decel_request(decel_request), .start_voltage_boost(boost), .start_slip_freq(slip),
    .start_torque(torque));

  motor_brake_model i_motor (
    .sys_clk(sys_clk), .nrst(nrst), .motor_on(motor_on), .brake_open(brake_open),
    .hold_zero_speed(hold_zero_speed), .decel_request(decel_request),
    .target_speed(target_speed), .speed_setpoint(speed_setpoint), .actual_speed(actual_speed));

  task automatic end_of_test();
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Hold the request until waitrequest is sampled low, then release it
  task automatic bus_cycle(input logic wr, input logic [6:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    // No own limit: only the watchdog ends a wait for the slave
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus_cycle

  task automatic wr(input logic [6:0] a, input logic [31:0] wd);
    logic [31:0] unused;
    bus_cycle(1'b1, a, wd, unused);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [31:0] v);
    bus_cycle(1'b0, a, 32'h0, v);
  endtask : rd

  // Count edges until the chosen output reaches a level; 0 brake, 1 motor, 2 hold
  task automatic wait_for(input int sel, input logic val, output int k);
    logic s;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      s = (sel == 0) ? brake_open : (sel == 1) ? motor_on : hold_zero_speed;
    end while (s !== val && k < 2000);
  endtask : wait_for

  task automatic in_range(input int k, input int lo, input int hi);
    check({31'h0, (k >= lo && k <= hi)}, 32'h1);
  endtask : in_range

  always @(posedge sys_clk)
    if (seq_watch && brake_open === 1'b1)
      check({31'h0, motor_on}, 32'h1);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Watchdog sized well beyond the longest sequence
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    {nrst, avs_read, avs_write, sel_lo, sel_hi, local_on, local_ramp_stop} = '0;
    {local_quick_stop, local_coast_stop, interconnect_on, seq_watch} = '0;
    avs_address = 7'h00;
    avs_writedata = 32'h0;
    target_speed = 16'h00c8;
    miscompares = 0;
    checks = 0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`OFS_CMDSET, d); check(d, 32'h20);
    rd(`OFS_STATUS, d); check(d, 32'h0);
    // Count change is refused outside commissioning and for out-of-range values
    wr(`OFS_CMDSET, 32'h40); rd(`OFS_CMDSET, d); check(d, 32'h20);
    wr(`OFS_CMDSET, 32'h2f); wr(`OFS_CMDSET, 32'h5f);
    rd(`OFS_CMDSET, d); check(d, 32'h2f);
    wr(`OFS_CMDSET, 32'h4f); wr(`OFS_CMDSET, 32'h40);
    rd(`OFS_CMDSET, d); check(d, 32'h40);
    // Walk every selection code
    for (int k = 0; k < 4; k++) begin
      sel_lo <= k[0];
      sel_hi <= k[1];
      repeat (5) @(posedge sys_clk);
      check({30'h0, active_command_set}, k);
      rd(`OFS_STATUS, d); check({30'h0, d[1:0]}, k);
    end
    wr(`OFS_SET_CFG, 32'h1); wr(`OFS_COPY, 32'h08); wr(`OFS_COPY, 32'h18);
    rd(7'h48, d); check(d, 32'h1);
    rd(`OFS_COPY, d); check(d, 32'h08);
    sel_lo <= 1'b1;
    sel_hi <= 1'b0;
    wr(`OFS_MAG_TIME, 32'h2); wr(`OFS_OPEN_TIME, 32'h3); wr(`OFS_CLOSE_TIME, 32'h2);
    wr(`OFS_WATCH_TIME, 32'h32); wr(`OFS_PULSE_DELAY, 32'h4); wr(`OFS_THRESHOLD, 32'ha);
    wr(`OFS_BOOST, 32'h11); wr(`OFS_SLIP, 32'h22); wr(`OFS_TORQUE, 32'h33);
    seq_watch <= 1'b1;
    // Ramp stop, quick stop, then coast stop in mid-opening with vector mode
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_CTRL_MODE, (i == 2) ? 32'h14 : 32'h2);
      wr(`OFS_CTRL, 32'h11);
      wait_for(1, 1'b1, n); in_range(n, 0, 4);
      check({31'h0, brake_open}, 32'h0);
      wait_for(0, 1'b1, n); in_range(n, 8, 25);
      check({31'h0, hold_zero_speed}, 32'h1);
      check({boost, torque}, (i == 2) ? 32'h00000033 : 32'h00110000);
      check({16'h0, slip}, (i == 2) ? 32'h0 : 32'h22);
      if (i == 2) begin
        wr(`OFS_CTRL, 32'h19);
        wait_for(0, 1'b0, n); in_range(n, 0, 2);
        check({31'h0, motor_on}, 32'h0);
        rd(`OFS_STATUS, d); check({25'h0, d[6:4], 4'h0}, 32'h0);
      end else begin
        wait_for(2, 1'b0, n); in_range(n, 18, 35);
        repeat (60) @(posedge sys_clk);
        wr(`OFS_CTRL, (i == 0) ? 32'h13 : 32'h15);
        repeat (2) @(posedge sys_clk);
        check({30'h0, decel_request, brake_open}, 32'h3);
        wait_for(0, 1'b0, n); in_range(n, 30, 200);
        check({31'h0, motor_on}, 32'h1);
        wait_for(1, 1'b0, n); in_range(n, 8, 25);
      end
      wr(`OFS_CTRL, 32'h10);
    end
    // Local pins drive set 0
    sel_lo <= 1'b0;
    local_on <= 1'b1;
    wait_for(1, 1'b1, n); in_range(n, 1, 8);
    local_coast_stop <= 1'b1;
    wait_for(1, 1'b0, n); in_range(n, 1, 8);
    {local_on, local_coast_stop} <= 2'b00;
    sel_lo <= 1'b1;
    seq_watch <= 1'b0;
    // Locked, permanently open and interconnected brake modes
    wr(`OFS_CTRL, 32'h01);
    repeat (60) @(posedge sys_clk);
    check({31'h0, brake_open}, 32'h0);
    wr(`OFS_CTRL, 32'h20);
    repeat (5) @(posedge sys_clk);
    check({31'h0, brake_open}, 32'h1);
    // Let the open-mode stop finish and the motor switch off before the interconnected run
    wait_for(1, 1'b0, n); in_range(n, 1, 100);
    wr(`OFS_CTRL, 32'h00);
    wr(`OFS_CTRL, 32'h30);
    interconnect_on <= 1'b1;
    wait_for(0, 1'b1, n); in_range(n, 8, 30);
    interconnect_on <= 1'b0;
    wait_for(1, 1'b0, n); in_range(n, 1, 400);
    end_of_test();
  end
endmodule : cmdset_switch_brake_sequencer_tb
`default_nettype wire
